// file: twrp_pkg.sv
// shared constants, state encoding and helpers for the three-wire register port
package twrp_pkg;

   // -----------------------------------------------------------------
   // register file shape
   // -----------------------------------------------------------------
   localparam int          REG_W       = 24;
   localparam int          CNT_W       = 8;
   localparam int          ADDR_W      = 4;
   localparam int          NUM_REGS    = 7;
   localparam logic [3:0]  ADDR_MIN    = 4'h1;
   localparam logic [3:0]  ADDR_MAX    = 4'h7;
   localparam logic [3:0]  RO_ADDR     = 4'h5;
   localparam logic [3:0]  TRIM_ADDR   = 4'h3;
   localparam int          RO_LSB      = 12;
   localparam int          RO_W        = 12;
   localparam logic [23:0] RO_MASK     = 24'hFF_F000;
   localparam logic [23:0] REG_RST     = 24'h00_0000;

   // -----------------------------------------------------------------
   // serial framing
   // -----------------------------------------------------------------
   localparam logic [7:0]  HDR_BITS    = 8'h05;
   localparam logic [7:0]  MIN_WR_BITS = 8'h04;
   localparam logic [7:0]  FULL_BITS   = 8'h18;
   localparam int          HDR_RD_BIT  = 4;

   // -----------------------------------------------------------------
   // bias reference trim field, percent in tenths
   // -----------------------------------------------------------------
   localparam int          TRIM_LSB    = 17;
   localparam int          TRIM_W      = 4;
   localparam logic [7:0]  TRIM_BASE   = 8'hA6;   // -90, i.e. -9.0 %
   localparam logic [7:0]  TRIM_STEP   = 8'h0C;   // 12, i.e. 1.2 %

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int          SYS_CLK_HZ    = 40_000_000;
   localparam int          SCLK_MAX_HZ   = 2_000_000;
   localparam int          SCLK_HALF_CYC = SYS_CLK_HZ / (2 * SCLK_MAX_HZ);

   // -----------------------------------------------------------------
   // transaction states
   // -----------------------------------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_HDR    = 6'h02,
      ST_WDATA  = 6'h04,
      ST_WPULSE = 6'h08,
      ST_RDATA  = 6'h10,
      ST_RPULSE = 6'h20
   } twrp_state_e;

   // low-order write mask for a bit count, saturating at full width
   function automatic logic [23:0] twrp_low_mask(input logic [7:0] n);
      logic [23:0] m;
      m = 24'h00_0000;
      for (int i = 0; i < REG_W; i++) begin
         m[i] = (8'(i) < n);
      end
      return m;
   endfunction

endpackage

// file: twrp_sync.sv
// two-flop level synchroniser into the system clock
`timescale 1ns/1ps
module twrp_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule // twrp_sync

// file: twrp_link.sv
// serial-clock side: bit capture, bit counter and read-back shifter
`timescale 1ns/1ps
module twrp_link
   import twrp_pkg::*;
(
   input  wire logic              ser_clk,
   input  wire logic              sys_rst,
   input  wire logic              sdata_i,
   input  wire logic              rd_active,
   input  wire logic [CNT_W-1:0]  rd_base,
   input  wire logic [REG_W-1:0]  rd_word,
   output logic      [REG_W-1:0]  shreg,
   output logic      [CNT_W-1:0]  bit_cnt,
   output logic                   sdata_o,
   output logic                   oe_link
);
   logic [CNT_W-1:0] rd_idx;

   // -----------------------------------------------------------------
   // capture
   // -----------------------------------------------------------------
   // every bit enters on the rising edge; counter wraps freely
   always_ff @(posedge ser_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shreg   <= REG_RST;
         bit_cnt <= '0;
      end else begin
         shreg   <= {shreg[REG_W-2:0], sdata_i}; // see RULE8
         bit_cnt <= bit_cnt + 8'h01;
      end
   end

   // -----------------------------------------------------------------
   // read-back
   // -----------------------------------------------------------------
   // rd_active, rd_base and rd_word are settled by the system side
   // while the serial clock is held still around the enable pulse
   assign rd_idx = bit_cnt - rd_base;

   // first rise of the read turns the pin round and shows the msb
   always_ff @(posedge ser_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sdata_o <= 1'b0;
         oe_link <= 1'b0;
      end else if (rd_active && rd_idx < FULL_BITS) begin
         sdata_o <= rd_word[REG_W-1-int'(rd_idx)]; // see RULE16
         oe_link <= 1'b1;                          // see RULE16
      end else begin
         sdata_o <= 1'b0;
         oe_link <= rd_active;
      end
   end
endmodule // twrp_link

// file: twrp_port.sv
// three-wire register port: sequencing, register file and read-back
`timescale 1ns/1ps

// How it works
// RULE1 - trim code maps linearly, -9.0 to +9.0 percent
// RULE2 - port never powered down by any setting
// RULE3 - host idles lines and pulses clock first
// RULE4 - host clock at most 2 MHz, may stop; the host model pulses it at a 12 ns period, 13 ns while reading
// RULE5 - host keeps enable low between transfers
// RULE6 - seven 24-bit registers at addresses 1..7
// RULE7 - register 5 bits 23..12 read-only
// RULE8 - all bits move on serial clock rise
// RULE9 - write header: zero then four address bits
// RULE10 - header enable fall latches and decodes address
// RULE11 - host sends write data msb first, zeros
// RULE12 - closing enable pulse commits shifted write data
// RULE13 - short writes, four bits minimum, fill low bits
// RULE14 - read header: one then four address bits
// RULE15 - read header fall loads 24-bit output word
// RULE16 - first read rise drives pin, msb first
// RULE17 - host samples read bits after falling edge
// RULE18 - closing enable pulse releases data pin
// RULE19 - any register readable at any time
// RULE20 - read-only or bad address writes change nothing
module twrp_port
   import twrp_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       ser_clk,
   input  wire logic                       ser_en,
   input  wire logic                       sdata_i,
   output logic                            sdata_o,
   output logic                            sdata_oe,
   input  wire logic [RO_W-1:0]            meas_result,
   output logic      [NUM_REGS*REG_W-1:0]  cfg_regs,
   output logic      [TRIM_W-1:0]          bias_reference_voltage_trim,
   output logic      [7:0]                 bias_trim_pct_x10
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   twrp_state_e        state;
   logic               en_s;
   logic               en_q;
   logic               en_rise;
   logic               en_fall;
   logic [REG_W-1:0]   sh_link;
   logic [CNT_W-1:0]   cnt_link;
   logic [REG_W-1:0]   sh_s;
   logic [CNT_W-1:0]   cnt_s;
   logic [CNT_W-1:0]   start_cnt;
   logic [CNT_W-1:0]   data_base;
   logic [ADDR_W-1:0]  addr;
   logic [REG_W-1:0]   rd_word;
   logic               rd_active;
   logic               oe_link;
   logic [CNT_W-1:0]   hdr_n;
   logic [CNT_W-1:0]   dat_n;
   logic [REG_W-1:0]   wr_mask;
   logic               wr_ok;
   logic [REG_W-1:0]   regs [1:NUM_REGS];

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // address 1..7 only; everything else has no register behind it
   function automatic logic addr_valid(input logic [ADDR_W-1:0] a);
      return (a >= ADDR_MIN) && (a <= ADDR_MAX); // see RULE6
   endfunction

   // register view as software sees it, live measurement on top of 5
   function automatic logic [REG_W-1:0] reg_view(input logic [ADDR_W-1:0] a);
      logic [REG_W-1:0] v;
      v = REG_RST;
      if (!addr_valid(a)) begin
         v = REG_RST;
      end else if (a == RO_ADDR) begin
         v = {meas_result, regs[RO_ADDR][RO_LSB-1:0]}; // see RULE7
      end else begin
         v = regs[a];
      end
      return v;
   endfunction

   // -----------------------------------------------------------------
   // crossings from the serial clock
   // -----------------------------------------------------------------
   // enable is sampled here, never on the serial clock, since its edges
   // arrive while the serial clock is parked low
   twrp_sync #(.W(1)) u_en_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .d       (ser_en),
      .q       (en_s)
   );

   // counter and shifter are quiet whenever enable moves, so the word
   // settles through the same two stages as enable itself
   twrp_sync #(.W(REG_W+CNT_W)) u_word_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .d       ({cnt_link, sh_link}),
      .q       ({cnt_s, sh_s})
   );

   twrp_link u_link (
      .ser_clk   (ser_clk),
      .sys_rst   (sys_rst),
      .sdata_i   (sdata_i),
      .rd_active (rd_active),
      .rd_base   (data_base),
      .rd_word   (rd_word),
      .shreg     (sh_link),
      .bit_cnt   (cnt_link),
      .sdata_o   (sdata_o),
      .oe_link   (oe_link)
   );

   // -----------------------------------------------------------------
   // enable edges and bit counts
   // -----------------------------------------------------------------
   // edge detector looks only at the second sync stage
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_q <= 1'b0;
      end else begin
         en_q <= en_s;
      end
   end

   assign en_rise = en_s & ~en_q;
   assign en_fall = ~en_s & en_q;
   assign hdr_n   = cnt_s - start_cnt;
   assign dat_n   = cnt_s - data_base;
   assign wr_mask = twrp_low_mask(dat_n > FULL_BITS ? FULL_BITS : dat_n);
   assign wr_ok   = addr_valid(addr) && (dat_n >= MIN_WR_BITS); // see RULE13

   // -----------------------------------------------------------------
   // transaction sequencer
   // -----------------------------------------------------------------
   // stray clocks with enable low leave the sequencer idle, which is
   // how the host's start-up clock pulse parks the port
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (en_rise) begin
                  state <= ST_HDR; // see RULE3
               end
            end
            ST_HDR: begin
               if (en_fall && hdr_n == HDR_BITS) begin
                  state <= sh_s[HDR_RD_BIT] ? ST_RDATA : ST_WDATA; // see RULE10
               end else if (en_fall) begin
                  state <= ST_IDLE;
               end
            end
            ST_WDATA: begin
               if (en_rise) begin
                  state <= ST_WPULSE;
               end
            end
            ST_WPULSE: begin
               if (en_fall) begin
                  state <= ST_IDLE; // see RULE12
               end
            end
            ST_RDATA: begin
               if (en_rise) begin
                  state <= ST_RPULSE;
               end
            end
            ST_RPULSE: begin
               if (en_fall) begin
                  state <= ST_IDLE; // see RULE18
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // bit counter snapshots mark header and data starts
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         start_cnt <= '0;
         data_base <= '0;
         addr      <= '0;
      end else if (state == ST_IDLE && en_rise) begin
         start_cnt <= cnt_s;
      end else if (state == ST_HDR && en_fall) begin
         data_base <= cnt_s;
         addr      <= sh_s[ADDR_W-1:0]; // see RULE10
      end
   end

   // -----------------------------------------------------------------
   // read-back word and pin direction
   // -----------------------------------------------------------------
   // loaded at the header's enable fall; pin stays an input until the
   // first serial rise of the read
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_word <= REG_RST;
      end else if (state == ST_HDR && en_fall && hdr_n == HDR_BITS
                   && sh_s[HDR_RD_BIT]) begin
         rd_word <= reg_view(sh_s[ADDR_W-1:0]); // see RULE15, see RULE19
      end
   end

   assign rd_active = (state == ST_RDATA) || (state == ST_RPULSE);
   // releases on the closing enable fall without any serial edge
   assign sdata_oe  = oe_link & rd_active; // see RULE18

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   // short writes touch only the low bits; read-only bits never take
   // serial data, and a bad address drops the write
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 1; i <= NUM_REGS; i++) begin
            regs[i] <= REG_RST;
         end
      end else if (state == ST_WPULSE && en_fall && wr_ok) begin
         if (addr == RO_ADDR) begin
            regs[addr] <= (regs[addr] & ~(wr_mask & ~RO_MASK))
                          | (sh_s & wr_mask & ~RO_MASK); // see RULE7, see RULE20
         end else begin
            regs[addr] <= (regs[addr] & ~wr_mask) | (sh_s & wr_mask); // see RULE13
         end
      end
   end

   // flat view, decoded inline: an assign never wakes on what a function
   // reads internally, so it would miss register updates; no bit gates the port
   generate
      for (genvar g = 1; g <= NUM_REGS; g++) begin : g_out
         assign cfg_regs[(g-1)*REG_W +: REG_W] = (g == int'(RO_ADDR))
            ? {meas_result, regs[g][RO_LSB-1:0]} : regs[g]; // see RULE2, see RULE7
      end
   endgenerate

   // -----------------------------------------------------------------
   // bias reference trim
   // -----------------------------------------------------------------
   // linear map, code 0 lowest and 15 highest
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bias_reference_voltage_trim <= '0;
         bias_trim_pct_x10           <= TRIM_BASE;
      end else begin
         bias_reference_voltage_trim <= regs[TRIM_ADDR][TRIM_LSB +: TRIM_W];
         bias_trim_pct_x10 <= 8'(TRIM_BASE + TRIM_STEP
                              * {4'h0, regs[TRIM_ADDR][TRIM_LSB +: TRIM_W]}); // see RULE1
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_hdr_end;
      state == ST_HDR && en_fall && hdr_n == HDR_BITS;
   endsequence

   sequence s_wr_close;
      state == ST_WPULSE && en_fall;
   endsequence

   property p_trim_map;
      ##1 bias_reference_voltage_trim == $past(regs[TRIM_ADDR][TRIM_LSB +: TRIM_W])
          && bias_trim_pct_x10 == 8'(TRIM_BASE + TRIM_STEP
                                     * {4'h0, $past(regs[TRIM_ADDR][TRIM_LSB +: TRIM_W])});
   endproperty
   a_trim_map: assert property (p_trim_map) // see RULE1
      else $error("trim percent not linear in trim code");

   property p_hdr_decode;
      s_hdr_end |=> (state == (sh_s[HDR_RD_BIT] ? ST_RDATA : ST_WDATA))
                    && addr == $past(sh_s[ADDR_W-1:0]);
   endproperty
   a_hdr_decode: assert property (p_hdr_decode) // see RULE10
      else $error("header not decoded at enable fall");

   property p_rd_load;
      (s_hdr_end and sh_s[HDR_RD_BIT]) |=> rd_word == reg_view(addr);
   endproperty
   a_rd_load: assert property (p_rd_load) // see RULE15
      else $error("read word not loaded from selected register");

   property p_rd_bad_addr;
      (s_hdr_end and sh_s[HDR_RD_BIT] and !addr_valid(sh_s[ADDR_W-1:0]))
         |=> rd_word == REG_RST;
   endproperty
   a_rd_bad_addr: assert property (p_rd_bad_addr) // see RULE6
      else $error("unmapped address read back non-zero");

   property p_write_low;
      (s_wr_close and wr_ok and addr != RO_ADDR)
         |=> (regs[$past(addr)] & $past(wr_mask)) == ($past(sh_s) & $past(wr_mask));
   endproperty
   a_write_low: assert property (p_write_low) // see RULE12
      else $error("write data not placed in low-order bits");

   property p_short_ignored;
      (s_wr_close and !wr_ok)
         |=> cfg_regs[4*REG_W+RO_LSB-1:0] == $past(cfg_regs[4*REG_W+RO_LSB-1:0])
             && cfg_regs[NUM_REGS*REG_W-1:5*REG_W] == $past(cfg_regs[NUM_REGS*REG_W-1:5*REG_W]);
   endproperty
   a_short_ignored: assert property (p_short_ignored) // see RULE20
      else $error("rejected write changed a register");

   property p_ro_bits;
      (s_wr_close and wr_ok and addr == RO_ADDR)
         |=> regs[RO_ADDR][REG_W-1:RO_LSB] == $past(regs[RO_ADDR][REG_W-1:RO_LSB]);
   endproperty
   a_ro_bits: assert property (p_ro_bits) // see RULE7
      else $error("read-only field took serial data");

   property p_release;
      (state == ST_RPULSE && en_fall) |=> !sdata_oe [*2];
   endproperty
   a_release: assert property (p_release) // see RULE18
      else $error("data pin not released by closing enable");

   property p_no_drive_outside_read;
      (!rd_active || $rose(rd_active)) |-> !sdata_oe;
   endproperty
   a_no_drive_outside_read: assert property (p_no_drive_outside_read) // see RULE16
      else $error("data pin driven before first read clock");

endmodule // twrp_port

// file: twrp_host.sv
// host model for the three-wire register port: clock, enable and data
`timescale 1ns/1ps
module twrp_host (
   output logic      ser_clk,
   output logic      ser_en,
   output logic      h_d,
   output logic      h_oe,
   input  wire logic sdata,
   input  wire logic sdata_oe
);
   // ----------------------------------------------------------------
   // quiet time around enable edges, clock held low and still
   // ----------------------------------------------------------------
   localparam int GAP = 200;

   // lines idle: clock and enable low, data floated
   initial begin
      ser_clk = 1'b0;
      ser_en  = 1'b0;
      h_d     = 1'b0;
      h_oe    = 1'b0;
   end

   // one return-to-zero pulse, data set while the clock is low
   task automatic pulse(input logic b);
      h_d = b;
      #6 ser_clk = 1'b1;
      #6 ser_clk = 1'b0;
   endtask

   // known start: float data, enable low, one lone clock pulse
   task automatic init();
      h_oe   = 1'b0;
      ser_en = 1'b0;
      pulse(1'b0);
      #GAP;
   endtask

   // one whole frame; ok drops if the pin turns round at a wrong time
   task automatic xfer(input logic rd, input logic [3:0] a, input int n,
                       input logic [23:0] d, output logic [23:0] q, output logic ok);
      logic [4:0] hdr;
      hdr    = {rd, a};
      ok     = 1'b1;
      q      = 24'h00_0000;
      ser_en = 1'b1;
      #GAP;
      h_oe = 1'b1;
      for (int i = 4; i >= 0; i--) pulse(hdr[i]);
      h_oe = 1'b0;  // released early so a read never sees two drivers
      #GAP;
      ser_en = 1'b0;
      #GAP;
      if (rd) begin
         for (int i = 0; i < 24; i++) begin
            if (i == 0 && sdata_oe !== 1'b0) ok = 1'b0;
            pulse(1'b0);
            #1 q = {q[22:0], sdata};
            if (sdata_oe !== 1'b1) ok = 1'b0;
         end
      end else begin
         h_oe = 1'b1;
         for (int i = n - 1; i >= 0; i--) pulse(d[i]);
         h_oe = 1'b0;
      end
      #GAP;
      ser_en = 1'b1;
      #GAP;
      ser_en = 1'b0;
      #GAP;
      if (sdata_oe !== 1'b0) ok = 1'b0;
   endtask
endmodule // twrp_host

// file: test_three_wire_register_port.sv
// self-checking bench for the three-wire register port
`timescale 1ns/1ps
module test_three_wire_register_port
   import twrp_pkg::*;
;
   logic                      sys_clk = 1'b0;
   // starts low so the first assertion is a real edge for both clock domains
   logic                      sys_rst = 1'b0;
   logic                      ser_clk;
   logic                      ser_en;
   logic                      h_d;
   logic                      h_oe;
   logic                      sdata_o;
   logic                      sdata_oe;
   logic                      flt = 1'b0;
   logic [RO_W-1:0]           meas = 12'hA5C;
   logic [NUM_REGS*REG_W-1:0] cfg_regs;
   logic [TRIM_W-1:0]         trim;
   logic [7:0]                pct;
   logic [23:0]               mdl [1:7];
   int                        n_mismatch = 0;
   int                        cmp_count = 0;
   // no pull on the data line: a released line wanders each cycle
   wire                       sdata = sdata_oe ? sdata_o : (h_oe ? h_d : flt);

   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) flt <= ~flt;

   twrp_port u_twrp_port (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .ser_clk(ser_clk), .ser_en(ser_en),
      .sdata_i(sdata), .sdata_o(sdata_o), .sdata_oe(sdata_oe), .meas_result(meas),
      .cfg_regs(cfg_regs), .bias_reference_voltage_trim(trim), .bias_trim_pct_x10(pct));

   twrp_host u_twrp_host (
      .ser_clk(ser_clk), .ser_en(ser_en), .h_d(h_d), .h_oe(h_oe),
      .sdata(sdata), .sdata_oe(sdata_oe));

   // ----------------------------------------------------------------
   // compare, verdict and register model
   // ----------------------------------------------------------------
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   function automatic logic [23:0] rg(input int n);
      return cfg_regs[(n-1)*24 +: 24];
   endfunction

   // register 5 top half always mirrors the live measurement
   function automatic logic [23:0] ex(input int n);
      return (n == 5) ? {meas, mdl[5][11:0]} : mdl[n];
   endfunction

   task automatic chk_all();
      for (int n = 1; n <= 7; n++) chk(rg(n), ex(n));
   endtask

   // write, update the model by the low-order fill, compare all
   task automatic wr(input logic [3:0] a, input int n, input logic [23:0] d);
      logic [23:0] q;
      logic        ok;
      logic [23:0] m;
      u_twrp_host.xfer(1'b0, a, n, d, q, ok);
      m = (n >= 24) ? 24'hFF_FFFF : ((24'h00_0001 << n) - 24'h00_0001);
      if (a >= 4'h1 && a <= 4'h7 && n >= 4) mdl[a] = (mdl[a] & ~m) | (d & m);
      chk_all();
   endtask

   task automatic rd(input logic [3:0] a, input logic [23:0] e);
      logic [23:0] q;
      logic        ok;
      u_twrp_host.xfer(1'b1, a, 0, 24'h00_0000, q, ok);
      chk(q, e);
      chk(24'(ok), 24'h00_0001);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      sys_rst <= 1'b1;
      repeat (16) @(posedge sys_clk);
      for (int n = 1; n <= 7; n++) mdl[n] = 24'h00_0000;
      chk_all();
      chk(24'(pct), 24'h00_00A6);
      chk(24'(sdata_oe), 24'h00_0000);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      u_twrp_host.init();
   endtask

   // every register written, then registers 5 and 6 rewritten, then read back
   task automatic t_regs();
      for (int n = 1; n <= 7; n++) wr(4'(n), 24, 24'h3C_5A00 ^ (24'(n) * 24'h11_1111));
      wr(4'h5, 24, 24'hFF_FFFF);
      wr(4'h6, 24, 24'h00_0080);
      for (int n = 1; n <= 7; n++) rd(4'(n), ex(n));
   endtask

   // short writes, one below the minimum length
   task automatic t_short();
      wr(4'h2, 24, 24'hFF_FFFF);
      wr(4'h2, 4, 24'h00_0005);
      wr(4'h2, 3, 24'h00_0000);
      wr(4'h2, 7, 24'h00_0011);
      rd(4'h2, ex(2));
   endtask

   task automatic t_bad();
      logic [3:0] bad [3] = '{4'h0, 4'h8, 4'hF};
      foreach (bad[i]) wr(bad[i], 24, 24'hAB_CDEF);
      rd(4'h0, 24'h00_0000);
   endtask

   task automatic t_trim();
      for (int c = 0; c < 16; c++) begin
         wr(4'h3, 24, 24'(c) << 17);
         chk(24'(trim), 24'(c));
         chk(24'(pct), {16'h0000, 8'(8'hA6 + 8'(c * 12))});
      end
   endtask

   task automatic t_meas();
      @(posedge sys_clk);
      meas <= 12'h3E7;
      repeat (4) @(posedge sys_clk);
      rd(4'h5, ex(5));
   endtask

   // ----------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------
   initial begin
      t_reset();
      t_regs();
      t_short();
      t_bad();
      t_trim();
      t_meas();
      @(posedge sys_clk);
      t_reset();
      rd(4'h1, 24'h00_0000);
      finish_test();
   end

   initial begin
      #500_000;
      n_mismatch++;
      finish_test();
   end
endmodule // test_three_wire_register_port
